// File: sim/iosd_checker.sv
// port assertions for the i/o space access decoder
`timescale 1ns/1ps
module iosd_checker (
  input logic sys_clk,
  input logic reset,
  input logic op_valid,
  input logic [2:0] op_code,
  input logic [5:0] io_addr,
  input logic [7:0] data_addr,
  input logic data_write,
  input logic [7:0] write_data,
  input logic [7:0] upper_io_read,
  input logic [7:0] read_data,
  input logic skip_next,
  input logic op_refused,
  input logic upper_io_write,
  input logic [4:0] upper_io_index,
  input logic [7:0] timer2_control_a,
  input logic [7:0] timer2_compare_a
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic io_op;
  logic st_op;
  logic bit_op;
  assign io_op = op_valid && !data_write;
  assign st_op = op_valid && data_write;
  assign bit_op = io_op && (op_code inside {3'h3, 3'h4, 3'h5, 3'h6});
  a_bit_refuse: assert property (bit_op && io_addr[5] |=> op_refused)
    else $error("bit op above 0x1f accepted");
  a_refuse_cause: assert property (op_refused |-> $past(bit_op && io_addr[5]))
    else $error("refusal without cause");
  a_skip_cause: assert property (skip_next |-> $past(io_op && op_code inside {3'h5, 3'h6}))
    else $error("skip without test");
  a_upper_write: assert property (io_op && op_code == 3'h2 && io_addr[5]
    |=> upper_io_write && upper_io_index == $past(io_addr[4:0])) else $error("upper write");
  a_upper_read: assert property (io_op && op_code == 3'h1 && io_addr[5]
    |=> read_data == $past(upper_io_read)) else $error("upper read");
  a_alias_store: assert property (st_op && data_addr[7:5] == 3'h2
    |=> upper_io_write && upper_io_index == $past(data_addr[4:0])) else $error("alias store");
  a_compare_store: assert property (st_op && data_addr == 8'hB3
    |=> timer2_compare_a == $past(write_data)) else $error("compare store");
  a_control_mask: assert property (st_op && data_addr == 8'hB0
    |=> timer2_control_a == ($past(write_data) & 8'hF3)) else $error("control mask");
  a_reserved_store: assert property (st_op && data_addr == 8'hB5 |=> !upper_io_write
    && $stable(timer2_control_a) && $stable(timer2_compare_a)) else $error("reserved store");
endmodule // iosd_checker
bind iosd_access_decoder iosd_checker chk (.*);

// File: sim/iosd_core_model.sv
// processor core model issuing i/o and load/store operations
`timescale 1ns/1ps
module iosd_core_model (
  input logic sys_clk,
  output logic op_valid,
  output logic [2:0] op_code,
  output logic [5:0] io_addr,
  output logic [2:0] bit_sel,
  output logic [7:0] data_addr,
  output logic data_write,
  output logic [7:0] write_data,
  output logic [7:0] flag_event,
  output logic [7:0] upper_io_read,
  output logic [7:0] ext_status_bits
);
  initial begin
    {op_valid, data_write, op_code, io_addr, bit_sel} = '0;
    {data_addr, write_data, flag_event} = '0;
    upper_io_read = 8'hC3;
    ext_status_bits = 8'h00;
  end
  // one operation held through its taking edge, then released
  task automatic issue(input logic w, input logic [2:0] c, input logic [5:0] a,
      input logic [2:0] b, input logic [7:0] d, input logic [7:0] v);
    @(posedge sys_clk);
    #1;
    {op_valid, data_write, op_code, io_addr, bit_sel} = {1'b1, w, c, a, b};
    {data_addr, write_data} = {d, v};
    @(posedge sys_clk);
    #1;
    {op_valid, data_write} = 2'h0;
    {op_code, io_addr, bit_sel} = ~{op_code, io_addr, bit_sel};
    {data_addr, write_data} = ~{data_addr, write_data};
  endtask
  task automatic flag(input logic [7:0] f);
    @(posedge sys_clk);
    #1;
    flag_event = f;
    @(posedge sys_clk);
    #1;
    flag_event = 8'h00;
  endtask
  task automatic status(input logic [7:0] s);
    @(posedge sys_clk);
    #1;
    ext_status_bits = s;
  endtask
endmodule // iosd_core_model

// File: sim/tb.sv
// self-checking testbench for the i/o space access decoder
`timescale 1ns/1ps
module tb;
  logic sys_clk, reset, op_valid, data_write, skip_next, op_refused, upper_io_write;
  logic [2:0] op_code, bit_sel;
  logic [5:0] io_addr;
  logic [4:0] upper_io_index;
  logic [1:0] timer2_force_pulse;
  logic [7:0] data_addr, write_data, flag_event, upper_io_read, ext_status_bits, read_data;
  logic [7:0] timer2_control_a, timer2_control_b, timer2_count_value, timer2_compare_a;
  logic [7:0] timer2_compare_b, async_timer_clock_status, two_wire_bit_rate;
  logic [7:0] two_wire_status_prescale, two_wire_own_address;
  int n_errors = 0;
  int total_checks = 0;
  iosd_access_decoder dut (.*);
  iosd_core_model core (.*);
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic io(input logic [2:0] c, input logic [5:0] a, input logic [2:0] b,
      input logic [7:0] v);
    core.issue(1'b0, c, a, b, 8'h00, v);
  endtask
  task automatic st(input logic [7:0] d, input logic [7:0] v);
    core.issue(1'b1, 3'h0, 6'h00, 3'h0, d, v);
  endtask
  task automatic ld(input logic [7:0] d);
    core.issue(1'b0, 3'h7, 6'h00, 3'h0, d, 8'h00);
  endtask
  task automatic t_reset_values;
    logic [7:0] offs [9] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB6, 8'hB8, 8'hB9, 8'hBA};
    foreach (offs[i]) begin
      ld(offs[i]);
      chk("reset value", 8'h00, read_data);
    end
    $display("test reset_values done");
  endtask
  task automatic t_flags;
    core.flag(8'h28);
    io(3'h1, 6'h00, 3'h0, 8'h00);
    chk("flags", 8'h28, read_data);
    io(3'h3, 6'h00, 3'h3, 8'h00);
    io(3'h4, 6'h00, 3'h5, 8'h00);
    io(3'h2, 6'h00, 3'h0, 8'h00);
    io(3'h1, 6'h00, 3'h0, 8'h00);
    chk("flags", 8'h20, read_data);
    io(3'h2, 6'h00, 3'h0, 8'h20);
    io(3'h1, 6'h00, 3'h0, 8'h00);
    chk("flags", 8'h00, read_data);
    $display("test flags done");
  endtask
  task automatic t_bits;
    io(3'h2, 6'h05, 3'h0, 8'h41);
    io(3'h3, 6'h05, 3'h2, 8'h00);
    io(3'h4, 6'h05, 3'h0, 8'h00);
    io(3'h1, 6'h05, 3'h0, 8'h00);
    chk("bit ops", 8'h44, read_data);
    io(3'h5, 6'h05, 3'h6, 8'h00);
    chk("skip", 8'h01, {7'h00, skip_next});
    io(3'h6, 6'h05, 3'h6, 8'h00);
    chk("skip", 8'h00, {7'h00, skip_next});
    io(3'h6, 6'h05, 3'h0, 8'h00);
    chk("skip", 8'h01, {7'h00, skip_next});
    io(3'h3, 6'h25, 3'h1, 8'h00);
    chk("refused", 8'h01, {7'h00, op_refused});
    io(3'h4, 6'h1F, 3'h1, 8'h00);
    chk("refused", 8'h00, {7'h00, op_refused});
    $display("test bits done");
  endtask
  task automatic t_alias;
    st(8'h25, 8'h3C);
    io(3'h1, 6'h05, 3'h0, 8'h00);
    chk("alias", 8'h3C, read_data);
    io(3'h2, 6'h05, 3'h0, 8'h5A);
    ld(8'h25);
    chk("alias", 8'h5A, read_data);
    io(3'h2, 6'h3F, 3'h0, 8'h77);
    chk("upper index", 8'h9F, {upper_io_write, 2'h0, upper_io_index});
    st(8'h41, 8'h11);
    chk("upper index", 8'h81, {upper_io_write, 2'h0, upper_io_index});
    io(3'h1, 6'h3F, 3'h0, 8'h00);
    chk("upper read", 8'hC3, read_data);
    $display("test alias done");
  endtask
  task automatic t_ext;
    st(8'hB0, 8'hFF);
    ld(8'hB0);
    chk("control a", 8'hF3, read_data);
    st(8'hB3, 8'hA5);
    st(8'hB5, 8'hFF);
    ld(8'hB5);
    chk("reserved", 8'h00, read_data);
    ld(8'hB3);
    chk("compare a", 8'hA5, read_data);
    st(8'hB1, 8'hC5);
    chk("force", 8'h03, {6'h00, timer2_force_pulse});
    chk("control b", 8'h05, timer2_control_b);
    st(8'hB8, 8'h5A);
    chk("bit rate", 8'h5A, two_wire_bit_rate);
    st(8'hB2, 8'h96);
    chk("count value", 8'h96, timer2_count_value);
    st(8'hB4, 8'h69);
    chk("compare b", 8'h69, timer2_compare_b);
    st(8'hBA, 8'hA5);
    chk("own address", 8'hA5, two_wire_own_address);
    ld(8'hBA);
    chk("own address", 8'hA5, read_data);
    $display("test ext done");
  endtask
  task automatic t_status;
    core.status(8'hFF);
    st(8'hB6, 8'hFF);
    chk("clock status", 8'h7F, async_timer_clock_status);
    st(8'hB9, 8'hFF);
    ld(8'hB9);
    chk("status prescale", 8'hFB, read_data);
    core.status(8'h00);
    ld(8'hB9);
    chk("status prescale", 8'h03, read_data);
    st(8'hB6, 8'h00);
    chk("clock status", 8'h00, async_timer_clock_status);
    $display("test status done");
  endtask
  task automatic t_reset_again;
    @(posedge sys_clk);
    #1 reset = 1;
    @(posedge sys_clk);
    #1 reset = 0;
    chk("control a", 8'h00, timer2_control_a);
    chk("bit rate", 8'h00, two_wire_bit_rate);
    io(3'h1, 6'h05, 3'h0, 8'h00);
    chk("low io", 8'h00, read_data);
    $display("test reset_again done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    reset = 1;
    repeat (2) @(posedge sys_clk);
    #1 reset = 0;
    t_reset_values();
    t_flags();
    t_bits();
    t_alias();
    t_ext();
    t_status();
    t_reset_again();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end
endmodule // tb

// File: verilog/iosd_access_decoder.v
// i/o space access decoder: instruction decode and extended register map
//
// Summary of operation
// - bit set/clear only for i/o 0x00-0x1F
// - skip tests one bit in low range
// - written one clears flag, zero keeps
// - bit operations touch only the addressed bit
// - io instructions address 0x00 to 0x3F
// - data alias is i/o address plus 0x20
// - extended 0x60-0xFF by load/store only
// - io address field spans 64 locations
`timescale 1ns/1ps
`include "iosd_map.vh"
module iosd_access_decoder (
  sys_clk,
  reset,
  op_valid,
  op_code,
  io_addr,
  bit_sel,
  data_addr,
  data_write,
  write_data,
  flag_event,
  upper_io_read,
  ext_status_bits,
  read_data,
  skip_next,
  op_refused,
  upper_io_write,
  upper_io_index,
  timer2_control_a,
  timer2_control_b,
  timer2_force_pulse,
  timer2_count_value,
  timer2_compare_a,
  timer2_compare_b,
  async_timer_clock_status,
  two_wire_bit_rate,
  two_wire_status_prescale,
  two_wire_own_address
);
  input wire sys_clk;
  input wire reset;
  input wire op_valid;
  input wire [2:0] op_code;
  input wire [5:0] io_addr;
  input wire [2:0] bit_sel;
  input wire [7:0] data_addr;
  input wire data_write;
  input wire [7:0] write_data;
  input wire [7:0] flag_event;
  input wire [7:0] upper_io_read;
  input wire [7:0] ext_status_bits;
  output reg [7:0] read_data;
  output reg skip_next;
  output reg op_refused;
  output reg upper_io_write;
  output reg [4:0] upper_io_index;
  output reg [7:0] timer2_control_a;
  output reg [7:0] timer2_control_b;
  output reg [1:0] timer2_force_pulse;
  output reg [7:0] timer2_count_value;
  output reg [7:0] timer2_compare_a;
  output reg [7:0] timer2_compare_b;
  output reg [7:0] async_timer_clock_status;
  output reg [7:0] two_wire_bit_rate;
  output reg [7:0] two_wire_status_prescale;
  output reg [7:0] two_wire_own_address;

  // ----------------------------------------------------------------
  // address resolution
  // ----------------------------------------------------------------
  wire is_data_op;
  wire [7:0] data_from_io;
  wire [7:0] eff_addr;
  wire io_space;
  wire low_space;
  wire ext_space;
  wire bit_op;
  wire bit_op_unused_form;
  wire bit_op_ok;
  wire [7:0] io_offset;
  wire [7:0] low_read;
  wire [4:0] low_index;
  wire low_write_full;
  wire low_bit_set;
  wire low_bit_clear;
  wire io_write;
  wire any_read;

  assign is_data_op = data_write || (op_code == `IOSD_OP_DATA_READ);
  assign data_from_io = {2'b00, io_addr} + `IOSD_IO_DATA_OFFSET;
  assign eff_addr = is_data_op ? data_addr : data_from_io;
  assign io_offset = eff_addr - `IOSD_IO_DATA_OFFSET;
  assign io_space = (eff_addr >= `IOSD_IO_DATA_OFFSET) && (eff_addr < `IOSD_EXT_FIRST);
  assign low_space = io_space && (io_offset <= `IOSD_BIT_IO_LAST);
  assign ext_space = (eff_addr >= `IOSD_EXT_FIRST);
  assign low_index = io_offset[4:0];
  // data stores address by data_addr, so they never count as bit ops
  assign bit_op = !data_write && (op_code == `IOSD_OP_SET_BIT) ||
    !data_write && (op_code == `IOSD_OP_CLEAR_BIT) || !data_write && (op_code == `IOSD_OP_SKIP_SET) ||
    !data_write && (op_code == `IOSD_OP_SKIP_CLEAR);
  assign bit_op_unused_form = (op_code == `IOSD_OP_SET_BIT) || (op_code == `IOSD_OP_CLEAR_BIT) ||
    (op_code == `IOSD_OP_SKIP_SET) || (op_code == `IOSD_OP_SKIP_CLEAR);
  assign bit_op_ok = !data_write && (io_addr[5] == 1'b0);
  assign io_write = op_valid && (op_code == `IOSD_OP_IO_WRITE);
  assign low_write_full = low_space && ((op_valid && data_write) || io_write);
  assign low_bit_set = op_valid && bit_op_ok && (op_code == `IOSD_OP_SET_BIT);
  assign low_bit_clear = op_valid && bit_op_ok && (op_code == `IOSD_OP_CLEAR_BIT);
  assign any_read = op_valid && ((op_code == `IOSD_OP_IO_READ) ||
    (op_code == `IOSD_OP_DATA_READ));

  iosd_low_io_bank u_low_bank (
    .sys_clk(sys_clk),
    .reset(reset),
    .io_index(low_index),
    .write_full(low_write_full),
    .write_data(write_data),
    .bit_set(low_bit_set),
    .bit_clear(low_bit_clear),
    .bit_sel(bit_sel),
    .flag_event(flag_event),
    .flag_reg_index(`IOSD_FLAG_INDEX),
    .read_data(low_read)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  reg [7:0] next_read;
  always @* begin
    next_read = `IOSD_ZERO_BYTE;
    if (low_space) begin
      next_read = low_read;
    end else if (io_space) begin
      next_read = upper_io_read;
    end else if (ext_space) begin
      case (eff_addr)
        `IOSD_TIMER2_CONTROL_A: next_read = timer2_control_a;
        `IOSD_TIMER2_CONTROL_B: next_read = timer2_control_b; // force bits read zero
        `IOSD_TIMER2_COUNT_VALUE: next_read = timer2_count_value;
        `IOSD_TIMER2_COMPARE_A: next_read = timer2_compare_a;
        `IOSD_TIMER2_COMPARE_B: next_read = timer2_compare_b;
        `IOSD_ASYNC_TIMER_CLOCK_STATUS: next_read = async_timer_clock_status;
        `IOSD_TWO_WIRE_BIT_RATE: next_read = two_wire_bit_rate;
        `IOSD_TWO_WIRE_STATUS_PRESCALE: next_read = two_wire_status_prescale;
        `IOSD_TWO_WIRE_OWN_ADDRESS: next_read = two_wire_own_address;
        default: next_read = `IOSD_ZERO_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registered answers
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      read_data <= `IOSD_RESET_VALUE;
      skip_next <= 1'b0;
      op_refused <= 1'b0;
      upper_io_write <= 1'b0;
      upper_io_index <= 5'h00;
    end else begin
      skip_next <= 1'b0;
      op_refused <= op_valid && bit_op && !bit_op_ok;
      upper_io_write <= io_space && !low_space && ((op_valid && data_write) || io_write);
      upper_io_index <= io_offset[4:0];
      if (any_read) begin
        read_data <= next_read;
      end
      if (op_valid && bit_op_ok && (op_code == `IOSD_OP_SKIP_SET)) begin
        skip_next <= low_read[bit_sel];
      end
      if (op_valid && bit_op_ok && (op_code == `IOSD_OP_SKIP_CLEAR)) begin
        skip_next <= !low_read[bit_sel];
      end
    end
  end

  // ----------------------------------------------------------------
  // extended register file, data-space writes only
  // ----------------------------------------------------------------
  wire ext_write;
  assign ext_write = op_valid && data_write && ext_space;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      timer2_control_a <= `IOSD_RESET_VALUE;
      timer2_control_b <= `IOSD_RESET_VALUE;
      timer2_force_pulse <= 2'b00;
      timer2_count_value <= `IOSD_RESET_VALUE;
      timer2_compare_a <= `IOSD_RESET_VALUE;
      timer2_compare_b <= `IOSD_RESET_VALUE;
      async_timer_clock_status <= `IOSD_RESET_VALUE;
      two_wire_bit_rate <= `IOSD_RESET_VALUE;
      two_wire_status_prescale <= `IOSD_RESET_VALUE;
      two_wire_own_address <= `IOSD_RESET_VALUE;
    end else begin
      timer2_force_pulse <= 2'b00;
      // reserved bit 7 never follows the status input
      async_timer_clock_status <= (async_timer_clock_status & `IOSD_MASK_ASYNC_WRITE)
        | (ext_status_bits & `IOSD_MASK_ASYNC_STATUS);
      two_wire_status_prescale <= (two_wire_status_prescale & `IOSD_MASK_PRESCALE)
        | (ext_status_bits & `IOSD_MASK_STATUS_READ & ~`IOSD_MASK_PRESCALE);
      if (ext_write) begin
        case (data_addr)
          `IOSD_TIMER2_CONTROL_A: timer2_control_a <= write_data & `IOSD_MASK_CONTROL_A;
          `IOSD_TIMER2_CONTROL_B: begin
            timer2_control_b <= write_data & `IOSD_MASK_CONTROL_B_STORE;
            timer2_force_pulse <= write_data[7:6];
          end
          `IOSD_TIMER2_COUNT_VALUE: timer2_count_value <= write_data;
          `IOSD_TIMER2_COMPARE_A: timer2_compare_a <= write_data;
          `IOSD_TIMER2_COMPARE_B: timer2_compare_b <= write_data;
          `IOSD_ASYNC_TIMER_CLOCK_STATUS: async_timer_clock_status <=
            (write_data & `IOSD_MASK_ASYNC_WRITE) | (ext_status_bits & `IOSD_MASK_ASYNC_STATUS);
          `IOSD_TWO_WIRE_BIT_RATE: two_wire_bit_rate <= write_data;
          `IOSD_TWO_WIRE_STATUS_PRESCALE: two_wire_status_prescale <=
            (write_data & `IOSD_MASK_PRESCALE) |
            (ext_status_bits & `IOSD_MASK_STATUS_READ & ~`IOSD_MASK_PRESCALE);
          `IOSD_TWO_WIRE_OWN_ADDRESS: two_wire_own_address <= write_data;
          default: timer2_force_pulse <= 2'b00;
        endcase
      end
    end
  end
endmodule // iosd_access_decoder

// File: verilog/iosd_low_io_bank.v
// bit-addressable low i/o register bank with write-one-to-clear flags
`timescale 1ns/1ps
`include "iosd_map.vh"
module iosd_low_io_bank (
  sys_clk,
  reset,
  io_index,
  write_full,
  write_data,
  bit_set,
  bit_clear,
  bit_sel,
  flag_event,
  flag_reg_index,
  read_data
);
  input wire sys_clk;
  input wire reset;
  input wire [4:0] io_index;
  input wire write_full;
  input wire [7:0] write_data;
  input wire bit_set;
  input wire bit_clear;
  input wire [2:0] bit_sel;
  input wire [7:0] flag_event;
  input wire [4:0] flag_reg_index;
  output reg [7:0] read_data;

  // ----------------------------------------------------------------
  // storage: one location per low i/o address
  // ----------------------------------------------------------------
  reg [7:0] bank [0:31];
  wire is_flag_reg;
  wire [7:0] bit_mask;

  assign is_flag_reg = (io_index == flag_reg_index);
  assign bit_mask = 8'h01 << bit_sel;

  always @* begin
    read_data = bank[io_index];
  end

  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : gen_loc
      localparam [4:0] loc_index = g;
      always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          bank[g] <= `IOSD_RESET_VALUE;
        end else if (loc_index == flag_reg_index) begin
          // flags: event sets, a written one clears, set wins
          bank[g] <= (bank[g] & ~(((io_index == loc_index) && write_full) ? write_data :
            (((io_index == loc_index) && bit_set) ? bit_mask : `IOSD_ZERO_BYTE)))
            | flag_event;
        end else if (io_index == loc_index) begin
          if (write_full) begin
            bank[g] <= write_data;
          end else if (bit_set) begin
            bank[g] <= bank[g] | bit_mask;
          end else if (bit_clear) begin
            bank[g] <= bank[g] & ~bit_mask;
          end
        end
      end
    end
  endgenerate
endmodule // iosd_low_io_bank

// File: verilog/iosd_map.vh
// address map and field constants for the i/o space access decoder
`ifndef IOSD_MAP_VH
`define IOSD_MAP_VH
// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define IOSD_OP_NONE 3'h0
`define IOSD_OP_IO_READ 3'h1
`define IOSD_OP_IO_WRITE 3'h2
`define IOSD_OP_SET_BIT 3'h3
`define IOSD_OP_CLEAR_BIT 3'h4
`define IOSD_OP_SKIP_SET 3'h5
`define IOSD_OP_SKIP_CLEAR 3'h6
`define IOSD_OP_DATA_READ 3'h7
// data writes use a separate strobe
// ----------------------------------------------------------------
// address ranges
// ----------------------------------------------------------------
`define IOSD_BIT_IO_LAST 8'h1F
`define IOSD_IO_LAST 8'h3F
`define IOSD_IO_DATA_OFFSET 8'h20
`define IOSD_EXT_FIRST 8'h60
`define IOSD_EXT_LAST 8'hFF
`define IOSD_IO_ADDR_W 6
// ----------------------------------------------------------------
// data-space register offsets
// ----------------------------------------------------------------
`define IOSD_TIMER2_CONTROL_A 8'hB0
`define IOSD_TIMER2_CONTROL_B 8'hB1
`define IOSD_TIMER2_COUNT_VALUE 8'hB2
`define IOSD_TIMER2_COMPARE_A 8'hB3
`define IOSD_TIMER2_COMPARE_B 8'hB4
`define IOSD_ASYNC_TIMER_CLOCK_STATUS 8'hB6
`define IOSD_TWO_WIRE_BIT_RATE 8'hB8
`define IOSD_TWO_WIRE_STATUS_PRESCALE 8'hB9
`define IOSD_TWO_WIRE_OWN_ADDRESS 8'hBA
// ----------------------------------------------------------------
// writable bit masks and reset value
// ----------------------------------------------------------------
`define IOSD_MASK_CONTROL_A 8'hF3
`define IOSD_MASK_CONTROL_B_STORE 8'h0F
`define IOSD_MASK_FORCE 8'hC0
`define IOSD_MASK_ASYNC_WRITE 8'h60
`define IOSD_MASK_ASYNC_STATUS 8'h1F
`define IOSD_FLAG_INDEX 5'h00
`define IOSD_MASK_PRESCALE 8'h03
`define IOSD_MASK_STATUS_READ 8'hFB
`define IOSD_RESET_VALUE 8'h00
`define IOSD_ZERO_BYTE 8'h00
`define IOSD_FLAG_COUNT 8
`endif
